/* hw/izs_pkg.sv */
// shared constants and types for the interpolating zero-stuff datapath
package izs_pkg;

  // ****************************************
  // sample format and filter geometry
  // ****************************************
  localparam int                  IZS_DATA_W    = 14;            // sample width, offset binary
  localparam int                  IZS_TAPS      = 43;            // half-band length
  localparam int                  IZS_PAIRS     = 11;            // nonzero symmetric pairs
  localparam int                  IZS_HIST      = 2 * IZS_PAIRS; // input history depth
  localparam int                  IZS_CENTRE    = 10;            // history slot on the centre tap
  localparam int                  IZS_COEF_W    = 16;            // coefficient width
  localparam int                  IZS_COEF_FRAC = 15;            // fraction bits of coefficients
  localparam int                  IZS_ACC_W     = 36;            // accumulator width
  localparam logic [IZS_DATA_W-1:0] IZS_MIDSCALE = 14'h2000;     // msb set, rest clear
  localparam logic [IZS_DATA_W-1:0] IZS_POS_MAX  = 14'h1fff;     // largest signed word
  localparam logic [IZS_DATA_W-1:0] IZS_NEG_MAX  = 14'h2000;     // smallest signed word

  // ****************************************
  // rates and buffering
  // ****************************************
  localparam int IZS_IN_RATE_MSPS   = 160;  // fastest source sample rate
  localparam int IZS_CORE_RATE_MSPS = 400;  // fastest converter update rate
  localparam int IZS_CLK_MHZ        = 10;   // clk_in rate, one core word per edge at most
  localparam int IZS_FIFO_DEPTH     = 32;   // input buffer depth
  localparam int IZS_READY_SLACK    = 3;    // free slots kept for words in flight

  // ****************************************
  // output sequence and state
  // ****************************************
  typedef enum logic [1:0] {
    IZS_IDLE,    // waiting for a buffered sample
    IZS_MID_A,   // midscale after first filter word
    IZS_OUT_B,   // second filter word
    IZS_MID_B    // midscale after second filter word
  } izs_step_t;

  typedef struct packed {
    logic [IZS_HIST-1:0][IZS_DATA_W-1:0] hist;      // input history, slot 0 newest
    izs_step_t                           step;      // output sequence position
    logic [IZS_DATA_W-1:0]               held;      // second filter word waiting
    logic [IZS_DATA_W-1:0]               dac_data;  // word to the converter core
    logic                                dac_valid; // core word pending
    logic [IZS_DATA_W-1:0]               in_data;   // captured input sample
    logic                                in_valid;  // captured sample to push
    logic                                ready;     // advertised room for input
  } izs_state_t;

  localparam izs_state_t IZS_STATE_RST = '0;  // all control clear after reset

endpackage

/* hw/izs_datapath.sv */
// input buffer, half-band interpolator and zero-stuff sequencer
`timescale 1ns/100ps

// ****************************************
// sample buffer
// ****************************************
module izs_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       arst_n_in,
  // filling side
  input  wire logic                       in_valid_in,
  input  wire logic [WIDTH-1:0]           in_data_in,
  output logic                            in_ready_out,
  // draining side
  output logic                            out_valid_out,
  output logic [WIDTH-1:0]                out_data_out,
  input  wire logic                       out_ready_in,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]      level_out
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int LVL_W = $clog2(DEPTH+1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr;    // write pointer
    logic [PTR_W-1:0] rd;    // read pointer
    logic [LVL_W-1:0] count; // words held
  } izs_fifo_state_t;

  izs_fifo_state_t  s;                  // registered state
  izs_fifo_state_t  next_s;             // next state
  logic [WIDTH-1:0] mem [DEPTH];        // storage, no reset needed
  logic             push;               // word written this edge
  logic             pop;                // word read this edge

  assign in_ready_out  = (s.count != LVL_FULL);
  assign out_valid_out = (s.count != '0);
  assign out_data_out  = mem[s.rd];
  assign level_out     = s.count;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr = (s.wr == PTR_LAST) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == PTR_LAST) ? '0 : s.rd + 1'b1;
    end
    next_s.count = s.count + LVL_W'(push) - LVL_W'(pop);
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[s.wr] <= in_data_in;
    end
  end

  // a full buffer never takes a word
  full_refuse_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (s.count == LVL_FULL) |-> !in_ready_out)
    else $error("buffer ready while full");

endmodule

// ****************************************
// interpolating datapath top
// ****************************************
module izs_datapath
  import izs_pkg::*;
#(
  parameter int                            FIFO_DEPTH  = izs_pkg::IZS_FIFO_DEPTH,
  parameter logic signed [izs_pkg::IZS_COEF_W-1:0] CENTRE_COEF = 16'sh4000,
  parameter logic signed [izs_pkg::IZS_COEF_W-1:0] PAIR_COEF [izs_pkg::IZS_PAIRS] =
    '{default: 16'sh0800}
) (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         arst_n_in,
  // sample source
  input  wire logic                         sample_valid_in,
  input  wire logic [izs_pkg::IZS_DATA_W-1:0] sample_in,
  output logic                              sample_ready_out,
  // static mode pins
  input  wire logic                         filter_response_select_in,
  input  wire logic                         zero_stuff_enable_in,
  // clock divider control
  input  wire logic                         clk_mult_enable_in,
  input  wire logic                         div_reset_in,
  // converter core
  output logic                              dac_valid_out,
  output logic [izs_pkg::IZS_DATA_W-1:0]    dac_data_out,
  input  wire logic                         dac_ready_in
);
  import izs_pkg::*;

  localparam int LVL_W = $clog2(FIFO_DEPTH+1);
  localparam logic [LVL_W-1:0] READY_LEVEL = LVL_W'(FIFO_DEPTH - IZS_READY_SLACK);

  izs_state_t                          s;            // registered state
  izs_state_t                          next_s;       // next state
  logic                                f_in_ready;   // buffer room
  logic                                f_out_valid;  // buffered sample present
  logic [IZS_DATA_W-1:0]               f_out_data;   // oldest buffered sample
  logic [LVL_W-1:0]                    f_level;      // buffer fill
  logic                                pop;          // sample taken by filter
  logic                                adv;          // core slot free
  logic [IZS_HIST-1:0][IZS_DATA_W-1:0] hist_sh;      // history with new sample
  logic signed [IZS_COEF_W-1:0]        centre_coef;  // mode dependent centre tap
  logic signed [IZS_ACC_W-1:0]         pair_term [IZS_PAIRS]; // weighted pair sums
  logic signed [IZS_ACC_W-1:0]         acc_b;        // odd phase sum
  logic signed [IZS_ACC_W-1:0]         acc_a;        // centre phase product
  logic                                div_clear;    // sequencer realign
  logic [IZS_DATA_W-1:0]               word_a;       // first filter word of a sample

  // offset binary to two's complement
  function automatic logic signed [IZS_DATA_W-1:0] to_signed(input logic [IZS_DATA_W-1:0] w);
    return signed'({~w[IZS_DATA_W-1], w[IZS_DATA_W-2:0]});
  endfunction

  // scale, saturate and return to offset binary
  function automatic logic [IZS_DATA_W-1:0] to_word(input logic signed [IZS_ACC_W-1:0] acc);
    logic signed [IZS_ACC_W-1:0] sh;
    logic        [IZS_DATA_W-1:0] w;
    sh = acc >>> IZS_COEF_FRAC;
    if (sh > IZS_ACC_W'(signed'(IZS_POS_MAX))) begin
      w = IZS_POS_MAX;
    end else if (sh < -IZS_ACC_W'(signed'({1'b0, IZS_NEG_MAX}))) begin
      w = IZS_NEG_MAX;
    end else begin
      w = sh[IZS_DATA_W-1:0];
    end
    return {~w[IZS_DATA_W-1], w[IZS_DATA_W-2:0]};
  endfunction

  // ****************************************
  // input buffer
  // ****************************************
  izs_fifo #(
    .WIDTH (IZS_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .in_valid_in   (s.in_valid),
    .in_data_in    (s.in_data),
    .in_ready_out  (f_in_ready),
    .out_valid_out (f_out_valid),
    .out_data_out  (f_out_data),
    .out_ready_in  (pop),
    .level_out     (f_level)
  );

  // ****************************************
  // half-band arithmetic
  // ****************************************
  // only the centre sign follows the mode; odd taps stay as they are
  assign centre_coef = filter_response_select_in ? -CENTRE_COEF : CENTRE_COEF;

  // history as it will be once the new sample is shifted in
  always_comb begin
    hist_sh[0] = f_out_data;
    for (int i = 1; i < IZS_HIST; i++) begin
      hist_sh[i] = s.hist[i-1];
    end
  end

  // symmetric pairs share one multiplier each
  for (genvar k = 0; k < IZS_PAIRS; k++) begin : g_pair
    logic signed [IZS_DATA_W:0] pair_sum; // pre-added mirror samples
    // widen each signed operand first so negative samples keep their sign
    assign pair_sum = (IZS_DATA_W+1)'(to_signed(hist_sh[k])) +
                      (IZS_DATA_W+1)'(to_signed(hist_sh[IZS_HIST-1-k]));
    assign pair_term[k] = IZS_ACC_W'(pair_sum * PAIR_COEF[k]);
  end

  // sum of odd phase and centre product
  always_comb begin
    acc_b = '0;
    for (int k = 0; k < IZS_PAIRS; k++) begin
      acc_b = acc_b + pair_term[k];
    end
    acc_a = IZS_ACC_W'(to_signed(hist_sh[IZS_CENTRE]) * centre_coef);
  end

  // first word of each sample, shared by the sequencer and its check
  assign word_a = to_word(acc_a);

  // ****************************************
  // capture and output sequencer
  // ****************************************
  assign adv       = !s.dac_valid || dac_ready_in;
  assign div_clear = div_reset_in && !clk_mult_enable_in;

  always_comb begin
    next_s = s;
    pop    = 1'b0;
    // input latch takes a word on any edge it is offered and accepted
    next_s.in_valid = sample_valid_in && s.ready;
    if (sample_valid_in && s.ready) begin
      next_s.in_data = sample_in;
    end
    // conservative room check covers the words already in flight
    next_s.ready = (f_level <= READY_LEVEL);
    if (adv) begin
      next_s.dac_valid = 1'b0;
    end
    // both mode pins are read on their own; any pairing is legal
    case (s.step)
      IZS_IDLE: begin
        // a realign edge pops nothing, so no buffered sample is lost
        if (adv && f_out_valid && !div_clear) begin
          pop              = 1'b1;
          next_s.hist      = hist_sh;
          next_s.dac_data  = word_a;
          next_s.held      = to_word(acc_b);
          next_s.dac_valid = 1'b1;
          next_s.step      = zero_stuff_enable_in ? IZS_MID_A : IZS_OUT_B;
        end
      end
      IZS_MID_A: begin
        if (adv) begin
          next_s.dac_data  = IZS_MIDSCALE;
          next_s.dac_valid = 1'b1;
          next_s.step      = IZS_OUT_B;
        end
      end
      IZS_OUT_B: begin
        if (adv) begin
          next_s.dac_data  = s.held;
          next_s.dac_valid = 1'b1;
          next_s.step      = zero_stuff_enable_in ? IZS_MID_B : IZS_IDLE;
        end
      end
      IZS_MID_B: begin
        if (adv) begin
          next_s.dac_data  = IZS_MIDSCALE;
          next_s.dac_valid = 1'b1;
          next_s.step      = IZS_IDLE;
        end
      end
      default: begin
        next_s.step = IZS_IDLE;
      end
    endcase
    // realign drops the half-done sample so phase restarts at the first word
    if (div_clear) begin
      next_s.step      = IZS_IDLE;
      next_s.dac_valid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= IZS_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign sample_ready_out = s.ready;
  assign dac_valid_out    = s.dac_valid;
  assign dac_data_out     = s.dac_data;

  // ****************************************
  // checks
  // ****************************************
  input_capture_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (sample_valid_in && sample_ready_out) |=> (s.in_valid && s.in_data == $past(sample_in)))
    else $error("accepted sample not captured");

  buffer_no_drop_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s.in_valid |-> f_in_ready)
    else $error("captured sample met a full buffer");

  first_word_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (pop && !div_clear) |=> (dac_valid_out && dac_data_out == $past(word_a)))
    else $error("first filter word missing");

  stuff_order_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (pop && zero_stuff_enable_in && !div_clear) |=> (s.step == IZS_MID_A))
    else $error("stuffing did not follow first word");

  midscale_word_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ((s.step == IZS_MID_A || s.step == IZS_MID_B) && adv && !div_clear)
      |=> (dac_valid_out && dac_data_out == IZS_MIDSCALE))
    else $error("inserted word not midscale");

  bypass_order_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (pop && !zero_stuff_enable_in && !div_clear) |=> (s.step == IZS_OUT_B))
    else $error("bypass mode inserted a word");

  centre_sign_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    filter_response_select_in |->
      (acc_a == -IZS_ACC_W'(to_signed(hist_sh[IZS_CENTRE]) * CENTRE_COEF)))
    else $error("high-pass centre tap not negated");

  div_realign_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    div_clear |=> (s.step == IZS_IDLE && !dac_valid_out))
    else $error("divider reset did not realign");

endmodule

/* verification/izs_source.sv */
// sample source model feeding the datapath input port
`timescale 1ns/100ps

// ****************************************
// sample source
// ****************************************
module izs_source
  import izs_pkg::*;
(
  // clock and handshake
  input  wire logic                  clk_in,
  input  wire logic                  ready_in,
  // sample bus
  output logic                       valid_out,
  output logic [IZS_DATA_W-1:0]      data_out
);
  // idle until the first offer
  initial begin
    valid_out = 1'b0;
    data_out  = '0;
  end

  // offer one word, wait until an edge samples ready high or bound edges pass
  task automatic send(input logic [IZS_DATA_W-1:0] w, input int bound, output logic ok);
    int n;
    @(negedge clk_in);
    valid_out = 1'b1;
    data_out  = w;
    ok = 1'b0;
    // at most one word per edge keeps the source within its rate
    for (n = 0; n < bound && !ok; n++) begin
      @(posedge clk_in);
      ok = (ready_in === 1'b1);
    end
  endtask

  // released bus shows the inverse so stale data never looks valid
  task automatic release_bus();
    @(negedge clk_in);
    valid_out = 1'b0;
    data_out  = ~data_out;
  endtask
endmodule

/* verification/test_interp_zero_stuff_datapath.sv */
// self-checking bench for the interpolating zero-stuff datapath
`timescale 1ns/100ps

module test_interp_zero_stuff_datapath;
  import izs_pkg::*;
  localparam logic signed [15:0] CC = 16'sh4000; // centre coefficient
  localparam logic signed [15:0] PC = 16'sh0800; // every pair coefficient

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic                  clk_in = 1'b0;    // 10 MHz clock
  logic                  arst_n_in = 1'b0; // async reset
  logic                  s_valid;          // source valid
  logic [IZS_DATA_W-1:0] s_data;           // source word
  logic                  s_ready;          // block ready
  logic                  frs = 1'b0;       // response select
  logic                  zs = 1'b0;        // zero-stuff enable
  logic                  mult = 1'b1;      // clock multiplier on
  logic                  divr = 1'b0;      // divider reset
  logic                  d_valid;          // core word valid
  logic [IZS_DATA_W-1:0] d_data;           // core word
  logic                  d_ready = 1'b0;   // core ready
  logic                  thr = 1'b0;       // toggle core ready
  logic                  rdy_lvl = 1'b0;   // core ready when not toggling
  logic [IZS_DATA_W-1:0] got[$];           // accepted core words
  logic [IZS_DATA_W-1:0] exp_q[$];         // expected core words
  int                    fails = 0;        // mismatches
  int                    compares = 0;     // comparisons

  always #50 clk_in = ~clk_in;

  // one process owns core ready, so no same-step double drive
  always @(negedge clk_in) d_ready <= thr ? ~d_ready : rdy_lvl;

  // collect every word the core takes
  always @(posedge clk_in) if (d_valid === 1'b1 && d_ready === 1'b1) got.push_back(d_data);

  izs_source src_u (.clk_in(clk_in), .ready_in(s_ready), .valid_out(s_valid), .data_out(s_data));

  izs_datapath #(.FIFO_DEPTH(32), .CENTRE_COEF(CC), .PAIR_COEF('{default: PC})) dut_u (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .sample_valid_in(s_valid), .sample_in(s_data),
    .sample_ready_out(s_ready), .filter_response_select_in(frs), .zero_stuff_enable_in(zs),
    .clk_mult_enable_in(mult), .div_reset_in(divr), .dac_valid_out(d_valid),
    .dac_data_out(d_data), .dac_ready_in(d_ready));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // offset binary to signed value
  function automatic longint sv(input logic [13:0] x);
    return longint'($signed(x ^ 14'h2000));
  endfunction

  // scale, saturate to 14 bit signed, back to offset binary
  function automatic logic [13:0] sat_code(input longint acc);
    longint v;
    v = acc >>> 15;
    if (v > 8191) v = 8191;
    else if (v < -8192) v = -8192;
    return 14'(v) ^ 14'h2000;
  endfunction

  // mode pins change only across a reset, held static afterwards
  task automatic do_reset(input logic f, input logic z);
    @(negedge clk_in);
    arst_n_in = 1'b0;
    frs = f;
    zs = z;
    repeat (4) @(negedge clk_in);
    arst_n_in = 1'b1;
    got.delete();
  endtask

  task automatic wait_words(input int n);
    int k;
    for (k = 0; k < 600 && got.size() < n; k++) @(posedge clk_in);
    if (got.size() < n) begin
      fails++;
      end_of_test();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // 30 back-to-back samples, the first 22 only prime the history
  task automatic run_mode(input logic f, input logic z);
    logic [13:0] h[22];
    logic [13:0] v;
    logic        ok;
    longint      acc;
    int          i;
    int          k;
    int          w;
    thr = 1'b1;
    do_reset(f, z);
    h = '{default: 14'h0};
    exp_q.delete();
    w = z ? 4 : 2;
    for (i = 0; i < 30; i++) begin
      v = 14'(i * 32'h0b57 + 32'h0123);
      src_u.send(v, 64, ok);
      check("sample taken", ok, 1'b1);
      for (k = 21; k > 0; k--) h[k] = h[k-1];
      h[0] = v;
      if (i >= 22) begin
        acc = (f ? -longint'(CC) : longint'(CC)) * sv(h[10]);
        exp_q.push_back(sat_code(acc));
        if (z) exp_q.push_back(14'h2000);
        acc = 0;
        for (k = 0; k < 11; k++) acc += longint'(PC) * (sv(h[k]) + sv(h[21-k]));
        exp_q.push_back(sat_code(acc));
        if (z) exp_q.push_back(14'h2000);
      end
    end
    src_u.release_bus();
    wait_words(30 * w);
    check("word count", got.size(), 30 * w);
    for (i = 0; i < exp_q.size(); i++) check("core word", got[22*w+i], exp_q[i]);
    $display("mode test done select %0d stuff %0d", f, z);
  endtask

  // stalled core: fill until refused, then drain to empty
  task automatic fill_drain();
    logic ok;
    int   acc;
    int   i;
    thr = 1'b0;
    rdy_lvl = 1'b0;
    do_reset(1'b0, 1'b0);
    acc = 0;
    for (i = 0; i < 40; i++) begin
      src_u.send(14'h3fff, 8, ok);
      if (!ok) break;
      acc++;
    end
    src_u.release_bus();
    check("refused when full", ok, 1'b0);
    check("fill in range", (acc >= 29 && acc <= 34), 1'b1);
    rdy_lvl = 1'b1;
    wait_words(2 * acc);
    repeat (10) @(posedge clk_in);
    check("drained count", got.size(), 2 * acc);
    check("saturated pair", got[got.size()-1], 14'h3fff);
    check("centre half", got[got.size()-2], 14'h2fff);
    $display("fill test done");
  endtask

  // divider reset ignored with multiplier on, drops pending words with it off
  task automatic div_reset_test(input logic m, input int n);
    logic ok;
    int   k;
    thr = 1'b0;
    rdy_lvl = 1'b0;
    do_reset(1'b0, 1'b1);
    src_u.send(14'h1234, 64, ok);
    check("divider sample taken", ok, 1'b1);
    src_u.release_bus();
    for (k = 0; k < 20 && d_valid !== 1'b1; k++) @(negedge clk_in);
    check("first word before pulse", d_valid, 1'b1);
    @(negedge clk_in);
    mult = m;
    divr = 1'b1;
    @(negedge clk_in);
    divr = 1'b0;
    mult = 1'b1;
    check("valid after divider pulse", d_valid, m);
    rdy_lvl = 1'b1;
    repeat (10) @(posedge clk_in);
    check("words after divider pulse", got.size(), n);
    $display("divider test done multiplier %0d", m);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    // all four pin combinations, direct IF with stuffing among them
    for (int m = 0; m < 4; m++) run_mode(m[0], m[1]);
    fill_drain();
    div_reset_test(1'b1, 4);
    div_reset_test(1'b0, 0);
    end_of_test();
  end

  initial begin
    #6000000;
    fails++;
    end_of_test();
  end
endmodule
